// file: src/rgc_gain_control.v
// Receiver gain supervisor with tracking calibration enables and Avalon-MM registers
//
// Behaviour
// RQ1: Every tracking enable may change at any time, traffic keeps flowing.
// RQ2: In direct FM mode, carrier-leak and quadrature transmit enables are forced off.
// RQ3: Three separate transmit tracking enables: predistortion, carrier leak, quadrature.
// RQ4: Five separate receive tracking enables: gain, offset, harmonic, flat, wideband quadrature.
// RQ5: External predistortion should alternate in time with transmit tracking.
// RQ6: Auto mode steers gain by itself as input level varies.
// RQ7: Auto decisions come from the peak detectors and the power detector.
// RQ8: Manual mode changes gain only on command write or pin request.
// RQ9: Manual mode with detectors enabled shows their indications on pins.
// RQ10: Fast attack reduces gain quickly, acting at once with a larger step.
// RQ11: Combined mode adds fast recovery with a larger step.
// RQ12: High-threshold overloads trigger gain reduction; two high thresholds exist.
// RQ13: Missed low thresholds trigger gain increase; two low thresholds exist.
// RQ14: Peak overrange when high overloads in a window reach a programmed count.
// RQ15: Power overrange when power is above the high threshold; reduce gain.
// RQ16: Front-end attenuation is matched by digital gain before output.
// RQ17: Peak underrange when low exceedances in a window stay under a count.
// RQ18: Power underrange when power stays at or below the low threshold.
// RQ19: Auto gain tracking disabled holds the last gain index.
// RQ20: Overrange and underrange together: reduce, no recovery.
`timescale 1ns/10ps
`include "rgc_map.vh"
module rgc_gain_control #(
  parameter DW = 16
) (
  clock,
  rst_b,
  address,
  read,
  write,
  byteenable,
  writedata,
  readdata,
  waitrequest,
  peakAnaHigh,
  peakHbHigh,
  peakAnaLow,
  peakHbLow,
  powerValid,
  powerLevel,
  pinGainUp,
  pinGainDown,
  pinOverrange,
  pinUnderrange,
  sampleValid,
  sampleIn,
  outValid,
  sampleOut,
  gainIndex,
  frontEndAtten,
  txPredistortionTrackEn,
  txCarrierLeakTrackEn,
  txQuadratureTrackEn,
  rxAutoGainTrackEn,
  rxBasebandOffsetTrackEn,
  rxSecondHarmonicTrackEn,
  rxFlatQuadratureTrackEn,
  rxWidebandQuadratureTrackEn
);
  input  wire                clock;
  input  wire                rst_b;
  input  wire        [4:0]   address;
  input  wire                read;
  input  wire                write;
  input  wire        [3:0]   byteenable;
  input  wire        [31:0]  writedata;
  output reg         [31:0]  readdata;
  output wire                waitrequest;
  input  wire                peakAnaHigh;
  input  wire                peakHbHigh;
  input  wire                peakAnaLow;
  input  wire                peakHbLow;
  input  wire                powerValid;
  input  wire        [15:0]  powerLevel;
  input  wire                pinGainUp;
  input  wire                pinGainDown;
  output reg                 pinOverrange;
  output reg                 pinUnderrange;
  input  wire                sampleValid;
  input  wire signed [DW-1:0] sampleIn;
  output wire                outValid;
  output wire signed [DW-1:0] sampleOut;
  output reg         [7:0]   gainIndex;
  output reg         [7:0]   frontEndAtten;
  output wire                txPredistortionTrackEn;
  output wire                txCarrierLeakTrackEn;
  output wire                txQuadratureTrackEn;
  output wire                rxAutoGainTrackEn;
  output wire                rxBasebandOffsetTrackEn;
  output wire                rxSecondHarmonicTrackEn;
  output wire                rxFlatQuadratureTrackEn;
  output wire                rxWidebandQuadratureTrackEn;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] neu;
    input [3:0]  be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        mergeBytes[i*8 +: 8] = be[i] ? neu[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  function [7:0] clampIdx;
    input [9:0] val;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (val[9] || (val[8:0] < {1'b0, lo})) begin
        clampIdx = lo;
      end else if (val[8:0] > {1'b0, hi}) begin
        clampIdx = hi;
      end else begin
        clampIdx = val[7:0];
      end
    end
  endfunction

  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  reg  [`RGC_CTRL_W-1:0] ctrl;
  reg  [7:0]             track;
  reg  [31:0]            peakCfg;
  reg  [31:0]            powerCfg;
  reg  [31:0]            stepCfg;
  reg                    ack;
  reg  [3:0]             status;
  reg                    cmdValid;
  reg  [7:0]             cmdIndex;
  wire                   busReq;
  wire                   wrDone;
  wire [31:0]            trackMerged;
  reg  [31:0]            next_readdata;

  assign busReq      = (read || write) && !ack;
  assign waitrequest = (read || write) && !ack;
  assign wrDone      = write && ack;
  assign trackMerged = mergeBytes({24'h000000, track}, writedata, byteenable);

  always @* begin
    case (address)
      `RGC_OFS_CTRL:   next_readdata = {{(32-`RGC_CTRL_W){1'b0}}, ctrl};
      `RGC_OFS_TRACK:  next_readdata = {24'h000000, track};
      `RGC_OFS_PEAK:   next_readdata = peakCfg;
      `RGC_OFS_POWER:  next_readdata = powerCfg;
      `RGC_OFS_GAIN:   next_readdata = {16'h0000, frontEndAtten, gainIndex};
      `RGC_OFS_STEP:   next_readdata = stepCfg;
      `RGC_OFS_STATUS: next_readdata = {28'h0000000, status};
      default:         next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack      <= 1'b0;
      readdata <= 32'h00000000;
      ctrl     <= `RGC_CTRL_RST;
      track    <= `RGC_TRACK_RST;
      peakCfg  <= `RGC_PEAK_RST;
      powerCfg <= `RGC_POWER_RST;
      stepCfg  <= `RGC_STEP_RST;
      cmdValid <= 1'b0;
      cmdIndex <= 8'h00;
    end else begin
      ack      <= busReq;
      cmdValid <= 1'b0;
      if (read && !ack) begin
        readdata <= next_readdata;
      end
      if (wrDone) begin
        case (address)
          `RGC_OFS_CTRL: begin
            if (byteenable[0]) begin
              ctrl <= writedata[`RGC_CTRL_W-1:0];
            end
          end
          `RGC_OFS_TRACK: begin
            track <= trackMerged[7:0]; // RQ1
          end
          `RGC_OFS_PEAK: begin
            peakCfg <= mergeBytes(peakCfg, writedata, byteenable);
          end
          `RGC_OFS_POWER: begin
            powerCfg <= mergeBytes(powerCfg, writedata, byteenable);
          end
          `RGC_OFS_GAIN: begin
            if (byteenable[0]) begin
              cmdValid <= 1'b1; // RQ8
              cmdIndex <= writedata[7:0];
            end
          end
          `RGC_OFS_STEP: begin
            stepCfg <= mergeBytes(stepCfg, writedata, byteenable);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Tracking enables
  // ----------------------------------------
  assign txPredistortionTrackEn      = track[`RGC_TRK_TXPD]; // RQ3
  assign txCarrierLeakTrackEn        = track[`RGC_TRK_TXLEAK] && !ctrl[`RGC_CTRL_DFM]; // RQ2
  assign txQuadratureTrackEn         = track[`RGC_TRK_TXQUAD] && !ctrl[`RGC_CTRL_DFM]; // RQ2
  assign rxAutoGainTrackEn           = track[`RGC_TRK_RXAGC]; // RQ4
  assign rxBasebandOffsetTrackEn     = track[`RGC_TRK_RXBB];
  assign rxSecondHarmonicTrackEn     = track[`RGC_TRK_RXHD];
  assign rxFlatQuadratureTrackEn     = track[`RGC_TRK_RXFLAT];
  assign rxWidebandQuadratureTrackEn = track[`RGC_TRK_RXWB];

  // ----------------------------------------
  // Detector windows
  // ----------------------------------------
  reg  [15:0] winCount;
  reg  [15:0] lastPower;
  wire        winEnd;
  wire        restart;
  wire [7:0]  highCnt;
  wire [7:0]  lowCnt;
  wire        autoRun;
  wire        peakOver;
  wire        peakUnder;
  wire        powerOver;
  wire        powerUnder;
  wire        anyOver;
  wire        anyUnder;
  wire        fastHit;

  assign autoRun = ctrl[`RGC_CTRL_AUTO] && rxAutoGainTrackEn;
  assign winEnd  = (winCount >= peakCfg[31:16]) || (peakCfg[31:16] < `RGC_WIN_MIN);
  assign restart = winEnd || fastHit;

  rgc_event_counter #(.W(8)) uHighCnt (
    .clock    (clock),
    .rst_b    (rst_b),
    .restart  (restart),
    .event_in (peakAnaHigh || peakHbHigh), // RQ12
    .count    (highCnt)
  );

  rgc_event_counter #(.W(8)) uLowCnt (
    .clock    (clock),
    .rst_b    (rst_b),
    .restart  (restart),
    .event_in (peakAnaLow || peakHbLow), // RQ13
    .count    (lowCnt)
  );

  assign peakOver   = (highCnt >= peakCfg[7:0]) && (peakCfg[7:0] != 8'h00); // RQ14
  assign peakUnder  = lowCnt < peakCfg[15:8]; // RQ17
  assign powerOver  = lastPower > powerCfg[15:0]; // RQ15
  assign powerUnder = lastPower <= powerCfg[31:16]; // RQ18
  assign anyOver    = peakOver || powerOver; // RQ7
  assign anyUnder   = peakUnder || powerUnder;
  assign fastHit    = autoRun && ctrl[`RGC_CTRL_FATK] && anyOver; // RQ10

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      winCount  <= 16'h0000;
      lastPower <= 16'h0000;
      status    <= 4'h0;
    end else begin
      winCount <= restart ? 16'h0001 : winCount + 16'h0001;
      if (powerValid) begin
        lastPower <= powerLevel;
      end
      if (winEnd) begin
        status <= {powerUnder, peakUnder, powerOver, peakOver};
      end
    end
  end

  // ----------------------------------------
  // Gain index steering
  // ----------------------------------------
  reg        upPrev;
  reg        downPrev;
  reg  [7:0] next_gainIndex;
  wire [7:0] minIdx;
  wire [7:0] maxIdx;
  wire [3:0] atkStep;
  wire [3:0] recStep;

  assign minIdx  = stepCfg[23:16];
  assign maxIdx  = stepCfg[31:24];
  assign atkStep = ctrl[`RGC_CTRL_FATK] ? stepCfg[7:4] : stepCfg[3:0]; // RQ10
  assign recStep = (ctrl[`RGC_CTRL_FATK] && ctrl[`RGC_CTRL_FREC]) ? stepCfg[15:12] : stepCfg[11:8]; // RQ11

  always @* begin
    next_gainIndex = gainIndex;
    if (autoRun) begin
      if (fastHit || (winEnd && anyOver)) begin
        next_gainIndex = clampIdx({2'b00, gainIndex} - {6'h00, atkStep}, minIdx, maxIdx); // RQ20
      end else if (winEnd && anyUnder) begin
        next_gainIndex = clampIdx({2'b00, gainIndex} + {6'h00, recStep}, minIdx, maxIdx); // RQ6
      end
    end else if (!ctrl[`RGC_CTRL_AUTO]) begin
      if (cmdValid) begin
        next_gainIndex = clampIdx({2'b00, cmdIndex}, minIdx, maxIdx); // RQ8
      end else if (pinGainDown && !downPrev) begin
        next_gainIndex = clampIdx({2'b00, gainIndex} - {6'h00, stepCfg[3:0]}, minIdx, maxIdx);
      end else if (pinGainUp && !upPrev) begin
        next_gainIndex = clampIdx({2'b00, gainIndex} + {6'h00, stepCfg[11:8]}, minIdx, maxIdx);
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gainIndex     <= `RGC_GAIN_RST;
      frontEndAtten <= 8'h00;
      upPrev        <= 1'b0;
      downPrev      <= 1'b0;
      pinOverrange  <= 1'b0;
      pinUnderrange <= 1'b0;
    end else begin
      gainIndex     <= next_gainIndex; // RQ19
      frontEndAtten <= maxIdx - next_gainIndex;
      upPrev        <= pinGainUp;
      downPrev      <= pinGainDown;
      pinOverrange  <= !ctrl[`RGC_CTRL_AUTO] && ctrl[`RGC_CTRL_PINEN] && anyOver; // RQ9
      pinUnderrange <= !ctrl[`RGC_CTRL_AUTO] && ctrl[`RGC_CTRL_PINEN] && anyUnder && !anyOver;
    end
  end

  // ----------------------------------------
  // Output compensation
  // ----------------------------------------
  rgc_gain_comp #(.W(DW)) uComp (
    .clock       (clock),
    .rst_b       (rst_b),
    .attenSteps  (frontEndAtten),
    .sampleValid (sampleValid),
    .sampleIn    (sampleIn),
    .outValid    (outValid),
    .sampleOut   (sampleOut)
  );
endmodule // rgc_gain_control

// file: include/rgc_map.vh
// Register offsets, fields, reset values and timing counts of the gain supervisor
`ifndef RGC_MAP_VH
`define RGC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RGC_OFS_CTRL    5'h00
`define RGC_OFS_TRACK   5'h04
`define RGC_OFS_PEAK    5'h08
`define RGC_OFS_POWER   5'h0C
`define RGC_OFS_GAIN    5'h10
`define RGC_OFS_STEP    5'h14
`define RGC_OFS_STATUS  5'h18

// ----------------------------------------
// Control fields
// ----------------------------------------
`define RGC_CTRL_AUTO   0
`define RGC_CTRL_FATK   1
`define RGC_CTRL_FREC   2
`define RGC_CTRL_DFM    3
`define RGC_CTRL_PINEN  4
`define RGC_CTRL_W      5

// ----------------------------------------
// Tracking enable fields
// ----------------------------------------
`define RGC_TRK_TXPD    0
`define RGC_TRK_TXLEAK  1
`define RGC_TRK_TXQUAD  2
`define RGC_TRK_RXAGC   3
`define RGC_TRK_RXBB    4
`define RGC_TRK_RXHD    5
`define RGC_TRK_RXFLAT  6
`define RGC_TRK_RXWB    7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RGC_CTRL_RST    5'h01
`define RGC_TRACK_RST   8'h08
`define RGC_PEAK_RST    32'h0100_0402
`define RGC_POWER_RST   32'h0400_4000
`define RGC_STEP_RST    32'hFFC3_4182
`define RGC_GAIN_RST    8'hFF

// ----------------------------------------
// Compensation and timing
// ----------------------------------------
`define RGC_IDX_PER_6DB 8'h06
`define RGC_WIN_MIN     16'h0001

`endif

// file: src/rgc_event_counter.v
// Saturating counter of detector threshold events within one decision window
`timescale 1ns/10ps
module rgc_event_counter #(
  parameter W = 8
) (
  clock,
  rst_b,
  restart,
  event_in,
  count
);
  input  wire         clock;
  input  wire         rst_b;
  input  wire         restart;
  input  wire         event_in;
  output reg  [W-1:0] count;

  // ----------------------------------------
  // Count, restarting at each window edge
  // ----------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= {W{1'b0}};
    end else if (restart) begin
      count <= {{(W-1){1'b0}}, event_in};
    end else if (event_in && (count != {W{1'b1}})) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // rgc_event_counter

// file: src/rgc_gain_comp.v
// Digital compensation of front-end attenuation on the receive samples
`timescale 1ns/10ps
`include "rgc_map.vh"
module rgc_gain_comp #(
  parameter W = 16
) (
  clock,
  rst_b,
  attenSteps,
  sampleValid,
  sampleIn,
  outValid,
  sampleOut
);
  input  wire                clock;
  input  wire                rst_b;
  input  wire        [7:0]   attenSteps;
  input  wire                sampleValid;
  input  wire signed [W-1:0] sampleIn;
  output reg                 outValid;
  output reg  signed [W-1:0] sampleOut;

  wire        [7:0]     shiftBy;
  wire signed [W+39:0]  wide;
  wire signed [W+39:0]  maxPos;
  wire signed [W+39:0]  maxNeg;
  reg  signed [W-1:0]   next_sampleOut;

  // ----------------------------------------
  // Shift up one bit per 6 dB of attenuation
  // ----------------------------------------
  assign shiftBy = attenSteps / `RGC_IDX_PER_6DB;
  assign wide    = $signed({{40{sampleIn[W-1]}}, sampleIn}) <<< (shiftBy > 8'h27 ? 8'h27 : shiftBy); // RQ16
  assign maxPos  = $signed({{41{1'b0}}, {(W-1){1'b1}}});
  assign maxNeg  = -maxPos - $signed({{(W+39){1'b0}}, 1'b1});

  always @* begin
    if (wide > maxPos) begin
      next_sampleOut = maxPos[W-1:0];
    end else if (wide < maxNeg) begin
      next_sampleOut = maxNeg[W-1:0];
    end else begin
      next_sampleOut = wide[W-1:0];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      outValid  <= 1'b0;
      sampleOut <= {W{1'b0}};
    end else begin
      outValid  <= sampleValid;
      if (sampleValid) begin
        sampleOut <= next_sampleOut; // RQ16
      end
    end
  end
endmodule // rgc_gain_comp

// file: sim/rgc_gain_control_props.sv
// Concurrent checks on the gain supervisor ports
`timescale 1ns/10ps
module rgc_gain_control_props (
  input wire        clock,
  input wire        rst_b,
  input wire [4:0]  address,
  input wire        read,
  input wire        write,
  input wire [3:0]  byteenable,
  input wire [31:0] writedata,
  input wire        waitrequest,
  input wire        pinGainUp,
  input wire        pinGainDown,
  input wire        pinOverrange,
  input wire        pinUnderrange,
  input wire        sampleValid,
  input wire        outValid,
  input wire [7:0]  gainIndex,
  input wire [7:0]  frontEndAtten,
  input wire        txCarrierLeakTrackEn,
  input wire        txQuadratureTrackEn,
  input wire        rxAutoGainTrackEn
);
  // ----------------------------------------
  // Mode mirror
  // ----------------------------------------
  reg  autoMode;
  reg  directFm;
  wire pinAny = pinGainUp || pinGainDown;
  wire ctrlWr = write && !waitrequest && address == 5'h00 && byteenable[0];
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      autoMode <= 1'b1;
      directFm <= 1'b0;
    end else if (ctrlWr) begin
      autoMode <= writedata[0];
      directFm <= writedata[3];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_dfm_off: assert property (directFm |-> !txCarrierLeakTrackEn && !txQuadratureTrackEn)
    else $error("transmit enables on in direct fm");
  chk_atten_track: assert property (frontEndAtten == 8'hFF - gainIndex)
    else $error("attenuation off gain");
  chk_out_drop: assert property ($fell(sampleValid) |=> !outValid && $past(outValid))
    else $error("output valid wrong");
  chk_manual_hold: assert property (!autoMode && !$past(autoMode) && !$past(pinAny) && !$past(pinAny, 2)
    && !$past(write) && !$past(write, 2) |-> $stable(gainIndex))
    else $error("manual gain moved");
  chk_agc_hold: assert property (autoMode && !rxAutoGainTrackEn && !$past(rxAutoGainTrackEn)
    && !$past(write) && !$past(write, 2) |-> $stable(gainIndex))
    else $error("gain moved with tracking off");
  chk_gain_floor: assert property (gainIndex >= 8'hC3)
    else $error("gain below floor");
  chk_pin_auto: assert property ($past(autoMode) |-> !pinOverrange && !pinUnderrange)
    else $error("pins active in auto");
  chk_under_excl: assert property (pinUnderrange |-> !pinOverrange)
    else $error("under and over together");
  cov_attack: cover property (autoMode && gainIndex < $past(gainIndex));
  cov_manual: cover property (!autoMode && pinGainDown);
  cov_flag: cover property (pinOverrange);
endmodule // rgc_gain_control_props

// file: sim/rgc_bb_model.sv
// Baseband-side model driving the manual gain pins
`timescale 1ns/10ps
module rgc_bb_model (
  input  wire  clock,
  output logic pinGainUp,
  output logic pinGainDown
);
  initial begin
    pinGainUp = 1'b0;
    pinGainDown = 1'b0;
  end
  task automatic pulse(input logic down);
    begin
      @(posedge clock);
      if (down) pinGainDown <= 1'b1;
      else pinGainUp <= 1'b1;
      repeat (2) @(posedge clock);
      pinGainDown <= 1'b0;
      pinGainUp <= 1'b0;
    end
  endtask
endmodule // rgc_bb_model

// file: sim/tb.sv
// Self-checking bench for the gain supervisor
`timescale 1ns/10ps
module tb;
  logic        clock, rst_b, read, write, waitrequest;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd, v;
  logic        peakAnaHigh, peakHbHigh, peakAnaLow, peakHbLow, powerValid;
  logic [15:0] powerLevel, sampleIn, sampleOut;
  logic        pinGainUp, pinGainDown, pinOverrange, pinUnderrange, sampleValid, outValid, seen;
  logic [7:0]  gainIndex, frontEndAtten, g0, expGain, expG;
  logic        txPredistortionTrackEn, txCarrierLeakTrackEn, txQuadratureTrackEn, rxAutoGainTrackEn;
  logic        rxBasebandOffsetTrackEn, rxSecondHarmonicTrackEn, rxFlatQuadratureTrackEn;
  logic        rxWidebandQuadratureTrackEn;
  int          failures, cmp_count, seed, i, k, x, prev, sh;
  logic [31:0] rv [8] = '{32'h01, 32'h08, 32'h0100_0402, 32'h0400_4000, 32'hFF, 32'hFFC3_4182, 32'h0, 32'h0};
  wire  [7:0]  en = {rxWidebandQuadratureTrackEn, rxFlatQuadratureTrackEn, rxSecondHarmonicTrackEn,
                     rxBasebandOffsetTrackEn, rxAutoGainTrackEn, txQuadratureTrackEn, txCarrierLeakTrackEn,
                     txPredistortionTrackEn};
  rgc_gain_control #(.DW(16)) u_rgc_gain_control (.*);
  rgc_bb_model u_rgc_bb_model (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    begin
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clock);
      while (waitrequest !== 1'b0) begin
        @(posedge clock);
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
    end
  endtask
  task automatic step(input int lim, input int delta);
    int n;
    begin
      n = 0;
      @(negedge clock);
      while (gainIndex === expGain && n < lim) begin
        @(negedge clock);
        n++;
      end
      expGain = expGain + delta;
      chk(gainIndex, expGain);
    end
  endtask
  task automatic hit(input logic hb, input int n);
    begin
      @(posedge clock);
      peakAnaHigh <= !hb;
      peakHbHigh <= hb;
      repeat (n) @(posedge clock);
      peakAnaHigh <= 1'b0;
      peakHbHigh <= 1'b0;
    end
  endtask
  task automatic pwr(input logic [15:0] p);
    begin
      @(posedge clock);
      powerLevel <= p;
      powerValid <= 1'b1;
      @(posedge clock);
      powerValid <= 1'b0;
    end
  endtask
  task automatic setLow(input logic lv);
    begin
      @(posedge clock);
      peakAnaLow <= lv;
      peakHbLow <= lv;
    end
  endtask
  function automatic logic [15:0] sat(input int s, input int n);
    longint y;
    begin
      y = longint'(s) <<< n;
      if (y > 32767) y = 32767;
      else if (y < -32768) y = -32768;
      return y[15:0];
    end
  endfunction
  initial begin
    #1_000_000;
    failures++;
    summarize;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'had22;
    failures = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    {read, write, address, writedata, byteenable} = {2'b00, 5'h00, 32'h0, 4'hF};
    {peakAnaHigh, peakHbHigh, peakAnaLow, peakHbLow, powerValid} = 5'b00111;
    {powerLevel, sampleValid, sampleIn} = {16'h1000, 1'b0, 16'h0000};
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus(0, 5'(i * 4), 0);
      chk(rd, rv[i]);
    end
    chk(en, 8'h08);
    bus(1, 5'h1C, 32'hFFFF_FFFF);
    bus(0, 5'h1C, 0);
    chk(rd, 0);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      bus(1, 5'h00, {28'h0, v[8], 3'b001});
      bus(1, 5'h04, {24'h0, v[7:0]});
      bus(0, 5'h04, 0);
      chk(rd, {24'h0, v[7:0]});
      chk(en, v[7:0] & (v[8] ? 8'hF9 : 8'hFF));
    end
    bus(1, 5'h00, 32'h1);
    bus(1, 5'h04, 32'h08);
    expGain = 8'hFF;
    bus(1, 5'h08, 32'h0010_0402);
    hit(0, 1);
    step(40, 0);
    hit(0, 3);
    step(40, -2);
    hit(1, 3);
    step(40, -2);
    pwr(16'h5000);
    step(40, -2);
    pwr(16'h1000);
    setLow(0);
    step(40, 1);
    setLow(1);
    pwr(16'h0400);
    step(40, 1);
    setLow(0);
    pwr(16'h1000);
    hit(0, 3);
    step(40, -2);
    setLow(1);
    bus(1, 5'h08, 32'h00C8_0402);
    bus(1, 5'h00, 32'h3);
    hit(0, 3);
    step(4, -8);
    setLow(0);
    bus(1, 5'h00, 32'h7);
    step(230, 4);
    setLow(1);
    bus(1, 5'h00, 32'h1);
    bus(1, 5'h08, 32'h0010_0402);
    bus(1, 5'h04, 32'h0);
    chk(en[2:0], 3'h0);
    hit(0, 3);
    setLow(0);
    step(40, 0);
    setLow(1);
    bus(1, 5'h04, 32'h08);
    bus(1, 5'h00, 32'h10);
    hit(0, 3);
    seen = 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      seen = seen | (pinOverrange === 1'b1);
    end
    chk(seen, 1);
    chk(gainIndex, expGain);
    setLow(0);
    seen = 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      seen = seen | (pinUnderrange === 1'b1);
    end
    chk(seen, 1);
    setLow(1);
    for (k = 0; k < 2; k++) begin
      bus(1, 5'h10, k ? 32'hD0 : 32'h20);
      expG = k ? 8'hD0 : 8'hC3;
      sh = (255 - expG) / 6;
      repeat (2) @(negedge clock);
      bus(0, 5'h10, 0);
      chk(rd[15:0], {8'hFF - expG, expG});
      for (i = 0; i < 12; i++) begin
        x = $random(seed) >>> (i[0] ? 26 : 16);
        @(posedge clock);
        sampleValid <= 1'b1;
        sampleIn <= x[15:0];
        @(negedge clock);
        if (i > 0) chk({outValid, sampleOut}, {1'b1, sat(prev, sh)});
        prev = x;
      end
      @(posedge clock);
      sampleValid <= 1'b0;
    end
    u_rgc_bb_model.pulse(1);
    repeat (3) @(negedge clock);
    chk(gainIndex < 8'hD0, 1);
    g0 = gainIndex;
    u_rgc_bb_model.pulse(0);
    repeat (3) @(negedge clock);
    chk(gainIndex > g0, 1);
    summarize;
  end
endmodule // tb
bind rgc_gain_control rgc_gain_control_props u_rgc_gain_control_props (.*);
